//--- rtl/waveform_playback_sequencer.v
// Eight-channel waveform playback sequencer with trace readback
`timescale 1ns/100ps
`include "wps_regs.vh"
module waveform_playback_sequencer #(
  parameter CH = 8,
  parameter CW = 3,
  parameter DW = 12,
  parameter DEPTH = 1024,
  parameter AW = 10,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Trace write port
  input wire wr_en_in,
  input wire [CW-1:0] wr_chan_in,
  input wire [AW-1:0] wr_index_in,
  input wire [DW-1:0] wr_data_in,
  // Playback settings
  input wire free_run_control_in,
  input wire [1:0] trigger_kind_setting_in,
  input wire [1:0] trig_source_in,
  input wire [10:0] points_per_waveform_setting_in,
  input wire [15:0] output_rate_setting_in,
  input wire [31:0] repeat_rate_setting_in,
  input wire [12:0] burst_count_in,
  input wire hs_trig_invert_in,
  input wire hs_ready_invert_in,
  // Trigger pins
  input wire ext_trig_in,
  input wire hs_trig_n_in,
  // Playback outputs
  output wire [CH*DW-1:0] dac_out,
  output reg [AW-1:0] point_index_out,
  output reg busy_out,
  output reg trig_out,
  output reg hs_ready_n_out,
  // Readback request
  input wire rb_req_in,
  input wire [CW-1:0] rb_chan_in,
  input wire [1:0] rb_sel_in,
  input wire [AW-1:0] rb_first_in,
  input wire [AW-1:0] rb_last_in,
  input wire readback_binary_in,
  output reg rb_busy_out,
  // Readback byte stream
  output reg rb_valid_out,
  output reg [7:0] rb_byte_out,
  output reg rb_end_out,
  input wire rb_ready_in
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PLAY = 2'h1;
  localparam [1:0] RB_IDLE = 2'h0;
  localparam [1:0] RB_LOAD = 2'h1;
  localparam [1:0] RB_EMIT = 2'h2;

  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
  endfunction

  // Settings latched so that the reset default is defined
  reg [1:0] src_q;
  reg [1:0] kind_q;
  reg run_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      src_q <= `WPS_RST_SRC;
      kind_q <= `WPS_RST_KIND;
      run_q <= 1'b0;
    end else begin
      src_q <= trig_source_in;
      kind_q <= trigger_kind_setting_in;
      run_q <= free_run_control_in;
    end
  end

  // Pin synchronisers; stage one feeds only stage two
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg hs_s1_q;
  reg hs_s2_q;
  reg hs_s3_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      hs_s1_q <= 1'b1;
      hs_s2_q <= 1'b1;
      hs_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_trig_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      hs_s1_q <= hs_trig_n_in;
      hs_s2_q <= hs_s1_q;
      hs_s3_q <= hs_s2_q;
    end
  end

  wire hs_act = ~hs_s2_q ^ hs_trig_invert_in;
  wire hs_act_prev = ~hs_s3_q ^ hs_trig_invert_in;
  wire ext_evt = ext_s2_q & ~ext_s3_q;
  wire hs_evt = hs_act & ~hs_act_prev;
  reg trig_evt;

  always @* begin
    case (src_q)
      `WPS_SRC_IMM: trig_evt = 1'b1;
      `WPS_SRC_EXT: trig_evt = ext_evt;
      `WPS_SRC_HAND: trig_evt = hs_evt;
      default: trig_evt = 1'b0;
    endcase
  end

  // Effective limits; out-of-range point and burst counts clamp to the maximum
  wire pts_bad = (points_per_waveform_setting_in == 11'h000) ||
                 (points_per_waveform_setting_in > `WPS_MAX_POINTS);
  wire [10:0] pts_eff = pts_bad ? `WPS_MAX_POINTS : points_per_waveform_setting_in;
  wire [10:0] pts_m1 = pts_eff - 11'h001;
  wire [AW-1:0] last_idx = pts_m1[AW-1:0];
  wire burst_bad = (burst_count_in == 13'h0000) || (burst_count_in > `WPS_MAX_BURST);
  wire [12:0] burst_eff = burst_bad ? `WPS_MAX_BURST : burst_count_in;
  wire [12:0] burst_m1 = burst_eff - 13'h0001;
  wire [15:0] rate_m1 = (output_rate_setting_in == 16'h0000) ? 16'h0000 :
                        (output_rate_setting_in - 16'h0001);
  wire rep_en = (repeat_rate_setting_in != 32'h0000_0000);
  wire [31:0] rep_m1 = repeat_rate_setting_in - 32'h0000_0001;

  // Shared sample divider and repetition timer for all channels
  reg [15:0] div_q;
  reg [31:0] rep_q;
  wire int_tick = (div_q == rate_m1);
  wire rep_tick = rep_en && (rep_q == rep_m1);

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 16'h0000;
      rep_q <= 32'h0000_0000;
    end else if (!run_q) begin
      div_q <= 16'h0000;
      rep_q <= rep_m1; // First period starts as soon as run goes on
    end else begin
      div_q <= int_tick ? 16'h0000 : (div_q + 16'h0001);
      rep_q <= rep_tick ? 32'h0000_0000 : (rep_q + 32'h0000_0001);
    end
  end

  // Playback sequencer
  reg [1:0] st_q;
  reg [AW-1:0] idx_q;
  reg [12:0] seg_q;
  reg start;
  reg adv;
  wire seg_end = (idx_q == last_idx);
  wire seq_end = (seg_q == burst_m1);
  wire imm_src = (src_q == `WPS_SRC_IMM);
  wire fire = (st_q == ST_PLAY) && adv && run_q;

  always @* begin
    start = 1'b0;
    case (kind_q)
      `WPS_KIND_CONT: start = rep_en ? rep_tick : 1'b1;
      `WPS_KIND_SAMPLE: start = 1'b1;
      `WPS_KIND_SEGMENT: start = trig_evt;
      `WPS_KIND_BURST: start = trig_evt;
      default: start = 1'b0;
    endcase
  end

  always @* begin
    if (kind_q == `WPS_KIND_SAMPLE && !imm_src) begin
      adv = trig_evt;
    end else begin
      adv = int_tick;
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_IDLE;
      idx_q <= {AW{1'b0}};
      seg_q <= 13'h0000;
      trig_out <= 1'b0;
      busy_out <= 1'b0;
      point_index_out <= {AW{1'b0}};
    end else begin
      trig_out <= 1'b0;
      if (!run_q) begin
        st_q <= ST_IDLE;
        idx_q <= {AW{1'b0}};
        seg_q <= 13'h0000;
        busy_out <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (start) begin
              st_q <= ST_PLAY;
              idx_q <= {AW{1'b0}};
              seg_q <= 13'h0000;
              trig_out <= 1'b1;
              busy_out <= 1'b1;
            end
          end
          ST_PLAY: begin
            // Triggers here step sample kind from an external or handshake source; segment and burst kinds ignore them until the play-out ends
            if (fire) begin
              point_index_out <= idx_q;
              if (!seg_end) begin
                idx_q <= idx_q + 1'b1;
              end else begin
                idx_q <= {AW{1'b0}};
                case (kind_q)
                  `WPS_KIND_SAMPLE: begin
                    st_q <= ST_PLAY;
                  end
                  `WPS_KIND_CONT: begin
                    if (rep_en) begin
                      st_q <= ST_IDLE;
                      busy_out <= 1'b0;
                    end else begin
                      trig_out <= 1'b1;
                    end
                  end
                  `WPS_KIND_SEGMENT: begin
                    if (imm_src) begin
                      trig_out <= 1'b1;
                    end else begin
                      st_q <= ST_IDLE;
                      busy_out <= 1'b0;
                    end
                  end
                  `WPS_KIND_BURST: begin
                    if (!seq_end) begin
                      seg_q <= seg_q + 13'h0001;
                    end else begin
                      seg_q <= 13'h0000;
                      // Immediate source chains sequences without a gap
                      if (imm_src) begin
                        trig_out <= 1'b1;
                      end else begin
                        st_q <= ST_IDLE;
                        busy_out <= 1'b0;
                      end
                    end
                  end
                  default: st_q <= ST_IDLE;
                endcase
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Handshake ready: idle waiting for a start, or sample kind playing
  wire can_accept = run_q && (src_q == `WPS_SRC_HAND) &&
                    (((st_q == ST_IDLE) && (kind_q != `WPS_KIND_CONT)) ||
                     ((st_q == ST_PLAY) && (kind_q == `WPS_KIND_SAMPLE)));

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hs_ready_n_out <= 1'b1;
    end else begin
      hs_ready_n_out <= ~can_accept ^ hs_ready_invert_in;
    end
  end

  // Readback control registers
  reg [1:0] rb_st_q;
  reg [AW-1:0] rb_addr_q;
  reg [AW-1:0] rb_end_q;
  reg [CW-1:0] rb_chan_q;
  reg rb_bin_q;
  reg [15:0] rb_word_q;
  reg [2:0] rb_k_q;
  wire [CH*DW-1:0] rb_bus;

  // Per-channel trace memory, shared playback index
  genvar g;
  generate
    for (g = 0; g < CH; g = g + 1) begin : chan
      localparam [31:0] CH_ID = g;
      reg [DW-1:0] mem [0:DEPTH-1];
      reg [DW-1:0] smp_q;

      always @(posedge clk_in) begin
        if (wr_en_in && ({{(32-CW){1'b0}}, wr_chan_in} == CH_ID)) begin
          mem[wr_index_in] <= wr_data_in;
        end
      end

      always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          smp_q <= {DW{1'b0}};
        end else if (fire) begin
          smp_q <= mem[idx_q];
        end
      end

      // Value stays until the next fired sample
      assign dac_out[g*DW +: DW] = smp_q;
      assign rb_bus[g*DW +: DW] = mem[rb_addr_q];
    end
  endgenerate

  // Readback engine feeding the byte FIFO
  wire [DW-1:0] rb_pick = rb_bus[rb_chan_q*DW +: DW];
  wire [2:0] rb_kmax = rb_bin_q ? 3'h1 : 3'h4;
  wire rb_last_pt = (rb_addr_q == rb_end_q);
  wire rb_last_byte = (rb_k_q == rb_kmax);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_out_data;
  wire fifo_take = fifo_out_valid & (~rb_valid_out | rb_ready_in);
  wire rb_push = (rb_st_q == RB_EMIT);
  reg [7:0] rb_byte;

  always @* begin
    rb_byte = 8'h00;
    if (rb_bin_q) begin
      rb_byte = (rb_k_q == 3'h0) ? rb_word_q[15:8] : rb_word_q[7:0];
    end else begin
      case (rb_k_q)
        3'h0: rb_byte = hex_char(rb_word_q[15:12]);
        3'h1: rb_byte = hex_char(rb_word_q[11:8]);
        3'h2: rb_byte = hex_char(rb_word_q[7:4]);
        3'h3: rb_byte = hex_char(rb_word_q[3:0]);
        default: rb_byte = rb_last_pt ? `WPS_CHR_LF : `WPS_CHR_COMMA;
      endcase
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rb_st_q <= RB_IDLE;
      rb_addr_q <= {AW{1'b0}};
      rb_end_q <= {AW{1'b0}};
      rb_chan_q <= {CW{1'b0}};
      rb_bin_q <= 1'b0;
      rb_word_q <= 16'h0000;
      rb_k_q <= 3'h0;
      rb_busy_out <= 1'b0;
    end else begin
      case (rb_st_q)
        RB_IDLE: begin
          if (rb_req_in) begin
            rb_st_q <= RB_LOAD;
            rb_busy_out <= 1'b1;
            rb_chan_q <= rb_chan_in;
            rb_bin_q <= readback_binary_in;
            case (rb_sel_in)
              `WPS_RB_ONE: begin
                rb_addr_q <= rb_first_in;
                rb_end_q <= rb_first_in;
              end
              `WPS_RB_RANGE: begin
                rb_addr_q <= rb_first_in;
                rb_end_q <= (rb_last_in < rb_first_in) ? rb_first_in : rb_last_in;
              end
              default: begin
                rb_addr_q <= {AW{1'b0}};
                rb_end_q <= last_idx;
              end
            endcase
          end
        end
        RB_LOAD: begin
          rb_word_q <= {{(16-DW){1'b0}}, rb_pick};
          rb_k_q <= 3'h0;
          rb_st_q <= RB_EMIT;
        end
        RB_EMIT: begin
          // A full FIFO stalls the engine here
          if (fifo_in_ready) begin
            if (!rb_last_byte) begin
              rb_k_q <= rb_k_q + 3'h1;
            end else if (rb_last_pt) begin
              rb_st_q <= RB_IDLE;
              rb_busy_out <= 1'b0;
            end else begin
              rb_addr_q <= rb_addr_q + 1'b1;
              rb_st_q <= RB_LOAD;
            end
          end
        end
        default: rb_st_q <= RB_IDLE;
      endcase
    end
  end

  rb_fifo #(
    .W(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rb_fifo (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(rb_push),
    .in_data_in({rb_last_pt & rb_last_byte, rb_byte}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(~rb_valid_out | rb_ready_in)
  );

  // Output stage keeps the stream ports on flip-flops
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rb_valid_out <= 1'b0;
      rb_byte_out <= 8'h00;
      rb_end_out <= 1'b0;
    end else if (fifo_take) begin
      rb_valid_out <= 1'b1;
      rb_byte_out <= fifo_out_data[7:0];
      rb_end_out <= fifo_out_data[8];
    end else if (rb_ready_in) begin
      rb_valid_out <= 1'b0;
    end
  end
endmodule // waveform_playback_sequencer

//--- rtl/wps_regs.vh
// Constants for the waveform playback sequencer
`ifndef WPS_REGS_VH
`define WPS_REGS_VH

// Trigger sources
`define WPS_SRC_IMM 2'h0
`define WPS_SRC_EXT 2'h1
`define WPS_SRC_HAND 2'h2

// Trigger kinds
`define WPS_KIND_CONT 2'h0
`define WPS_KIND_SAMPLE 2'h1
`define WPS_KIND_SEGMENT 2'h2
`define WPS_KIND_BURST 2'h3

// Reset values of the latched settings
`define WPS_RST_SRC 2'h0
`define WPS_RST_KIND 2'h0

// Limits
`define WPS_MAX_POINTS 11'h400
`define WPS_MAX_BURST 13'h1000

// Readback selections
`define WPS_RB_ALL 2'h0
`define WPS_RB_ONE 2'h1
`define WPS_RB_RANGE 2'h2

// Text framing characters
`define WPS_CHR_COMMA 8'h2C
`define WPS_CHR_LF 8'h0A

`endif

//--- rtl/rb_fifo.v
// Readback byte FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rb_fifo #(
  parameter W = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Fill side
  input wire in_valid_in,
  input wire [W-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [W-1:0] out_data_out,
  input wire out_ready_in
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_out = (cnt_q != FULL_CNT);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Storage has no reset; only the pointers and the count need a defined state
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // rb_fifo

//--- verification/wps_monitor.sv
// Concurrent checks on the playback sequencer ports
`timescale 1ns/100ps
module wps_monitor (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Watched inputs
  input wire free_run_control_in,
  input wire [10:0] points_per_waveform_setting_in,
  input wire hs_ready_invert_in,
  input wire rb_req_in,
  input wire rb_ready_in,
  // Watched outputs
  input wire [95:0] dac_out,
  input wire [9:0] point_index_out,
  input wire busy_out,
  input wire trig_out,
  input wire hs_ready_n_out,
  input wire rb_busy_out,
  input wire rb_valid_out,
  input wire [7:0] rb_byte_out,
  input wire rb_end_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // Four idle cycles cover the latch and the last pending fire
  a_stop_dac_hold: assert property (!free_run_control_in [*4] |-> $stable(dac_out))
    else $error("dac moved while stopped");
  a_stop_no_play: assert property (!free_run_control_in [*4] |-> !busy_out && !trig_out)
    else $error("playing while stopped");
  a_trig_in_play: assert property (trig_out |-> busy_out)
    else $error("start pulse outside play");
  a_idx_below_pts: assert property ($stable(points_per_waveform_setting_in)
      && points_per_waveform_setting_in != 0 && points_per_waveform_setting_in <= 1024
      |-> point_index_out < points_per_waveform_setting_in)
    else $error("index past point count");
  // A change is only legal once a new play-out has begun
  a_end_hold: assert property ($fell(busy_out)
      |=> ($stable(dac_out) || $past(busy_out)) [*2])
    else $error("output moved after play end");
  a_rb_accept: assert property (rb_req_in && !rb_busy_out |=> rb_busy_out)
    else $error("readback not accepted");
  a_rb_first_byte: assert property (rb_req_in && !rb_busy_out && !rb_valid_out
      |-> ##4 rb_valid_out)
    else $error("first readback byte late");
  a_rb_stall_hold: assert property (rb_valid_out && !rb_ready_in
      |=> rb_valid_out && $stable(rb_byte_out) && $stable(rb_end_out))
    else $error("readback byte dropped in stall");
  // Ready is registered, so the polarity must hold over the last cycle
  a_ready_idle_lvl: assert property (!free_run_control_in [*4]
      && $stable(hs_ready_invert_in)
      |-> hs_ready_n_out == !hs_ready_invert_in)
    else $error("ready active while stopped");
endmodule // wps_monitor

//--- verification/trig_partner.sv
// Trigger source and handshake partner for the sequencer
`timescale 1ns/100ps
module trig_partner (
  // Clock and bench control
  input wire clk_in,
  input wire fire_in,
  input wire use_hs_in,
  input wire hs_inv_in,
  input wire ready_inv_in,
  // Ready from the sequencer
  input wire hs_ready_n_in,
  // Trigger pins
  output reg ext_trig_out,
  output wire hs_trig_n_out
);
  reg hs_act_q = 0;
  initial ext_trig_out = 0;
  // Idle level follows the chosen polarity
  assign hs_trig_n_out = ~(hs_act_q ^ hs_inv_in);
  always @(posedge clk_in) begin
    if (fire_in) begin
      if (use_hs_in) begin
        // Never fire before the sequencer can take it
        while ((hs_ready_n_in ^ ready_inv_in) !== 1'b0) @(posedge clk_in);
        hs_act_q <= 1;
        repeat (3) @(posedge clk_in);
        hs_act_q <= 0;
      end else begin
        // Held three clocks so the synchroniser cannot miss it
        ext_trig_out <= 1;
        repeat (3) @(posedge clk_in);
        ext_trig_out <= 0;
      end
    end
  end
endmodule // trig_partner

//--- verification/tb_top.sv
// Self-checking bench for the waveform playback sequencer
`timescale 1ns/100ps
`include "wps_regs.vh"
module tb_top;
  reg clk_in = 0;
  reg arst_n_in = 0;
  reg wr_en_in = 0, free_run_control_in = 0, hs_trig_invert_in = 0, hs_ready_invert_in = 0;
  reg [2:0] wr_chan_in = 0, rb_chan_in = 0;
  reg [9:0] wr_index_in = 0, rb_first_in = 0, rb_last_in = 0;
  reg [11:0] wr_data_in = 0;
  reg [1:0] trigger_kind_setting_in = 0, trig_source_in = 0, rb_sel_in = 0;
  reg [10:0] points_per_waveform_setting_in = 4;
  reg [15:0] output_rate_setting_in = 1;
  reg [31:0] repeat_rate_setting_in = 0;
  reg [12:0] burst_count_in = 1;
  reg rb_req_in = 0, readback_binary_in = 0, rb_ready_in = 0, fire = 0;
  wire ext_trig_in, hs_trig_n_in, busy_out, trig_out, hs_ready_n_out, rb_busy_out;
  wire rb_valid_out, rb_end_out;
  wire [95:0] dac_out;
  wire [9:0] point_index_out;
  wire [7:0] rb_byte_out;
  reg [11:0] tr [0:63];
  reg [8:0] exq [$];
  reg [95:0] prev_dac = 0;
  reg [31:0] seed = 32'hcd95_8434;
  integer n_fail = 0, cmp_count = 0, cyc_n = 0, k, n, g;

  waveform_playback_sequencer waveform_playback_sequencer_inst (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .wr_en_in(wr_en_in), .wr_chan_in(wr_chan_in),
    .wr_index_in(wr_index_in), .wr_data_in(wr_data_in), .free_run_control_in(free_run_control_in),
    .trigger_kind_setting_in(trigger_kind_setting_in), .trig_source_in(trig_source_in),
    .points_per_waveform_setting_in(points_per_waveform_setting_in),
    .output_rate_setting_in(output_rate_setting_in), .burst_count_in(burst_count_in),
    .repeat_rate_setting_in(repeat_rate_setting_in), .hs_trig_invert_in(hs_trig_invert_in),
    .hs_ready_invert_in(hs_ready_invert_in), .ext_trig_in(ext_trig_in), .dac_out(dac_out),
    .hs_trig_n_in(hs_trig_n_in), .point_index_out(point_index_out), .busy_out(busy_out),
    .trig_out(trig_out), .hs_ready_n_out(hs_ready_n_out), .rb_req_in(rb_req_in),
    .rb_chan_in(rb_chan_in), .rb_sel_in(rb_sel_in), .rb_first_in(rb_first_in),
    .rb_last_in(rb_last_in), .readback_binary_in(readback_binary_in), .rb_busy_out(rb_busy_out),
    .rb_valid_out(rb_valid_out), .rb_byte_out(rb_byte_out), .rb_end_out(rb_end_out),
    .rb_ready_in(rb_ready_in));
  trig_partner trig_partner_inst (.clk_in(clk_in), .fire_in(fire),
    .use_hs_in(trig_source_in == `WPS_SRC_HAND), .hs_inv_in(hs_trig_invert_in),
    .ready_inv_in(hs_ready_invert_in), .hs_ready_n_in(hs_ready_n_out),
    .ext_trig_out(ext_trig_in), .hs_trig_n_out(hs_trig_n_in));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [63:0] nm, input [15:0] e, input [15:0] v);
    begin
      cmp_count = cmp_count + 1;
      if (e !== v) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, v);
      end
    end
  endtask
  task final_report;
    begin
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task cyc;
    begin
      @(posedge clk_in);
      #1;
    end
  endtask
  task pull;
    begin
      @(posedge clk_in) fire <= 1;
      @(posedge clk_in) fire <= 0;
    end
  endtask
  // Stop, change settings while idle, then run again
  task setup(input [1:0] kd, input [1:0] sr, input [15:0] rt, input [31:0] rp);
    begin
      @(posedge clk_in) free_run_control_in <= 0;
      repeat (6) @(posedge clk_in);
      trigger_kind_setting_in <= kd;
      trig_source_in <= sr;
      output_rate_setting_in <= rt;
      repeat_rate_setting_in <= rp;
      repeat (3) @(posedge clk_in);
      free_run_control_in <= 1;
    end
  endtask
  task rb(input [2:0] ch, input [1:0] sl, input [9:0] f, input [9:0] l, input bn);
    reg [15:0] v;
    integer i, j, e;
    reg [7:0] h;
    begin
      e = (l < f) ? f : l;
      for (i = f; i <= e; i = i + 1) begin
        v = {4'h0, tr[ch * 8 + i]};
        if (bn) begin
          exq.push_back({1'b0, v[15:8]});
          exq.push_back({i == e, v[7:0]});
        end else begin
          for (j = 3; j >= 0; j = j - 1) begin
            h = (v >> (j * 4)) & 16'h000F;
            exq.push_back({1'b0, h < 10 ? 8'h30 + h : 8'h37 + h});
          end
          exq.push_back({i == e, i == e ? `WPS_CHR_LF : `WPS_CHR_COMMA});
        end
      end
      @(posedge clk_in);
      rb_chan_in <= ch;
      rb_sel_in <= sl;
      rb_first_in <= f;
      rb_last_in <= l;
      readback_binary_in <= bn;
      rb_req_in <= 1;
      @(posedge clk_in) rb_req_in <= 0;
      while (exq.size() != 0 || rb_busy_out !== 1'b0) cyc;
    end
  endtask

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc_n = cyc_n + 1;
    seed = xs(seed);
    rb_ready_in <= seed[0] | seed[1];
    if (cyc_n == 20000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  // Output watcher: samples against trace, bytes against notes
  always @(posedge clk_in) if (arst_n_in) begin
    if (dac_out !== prev_dac)
      for (g = 0; g < 8; g = g + 1)
        chk("dac", tr[g * 8 + point_index_out[2:0]], dac_out[g * 12 +: 12]);
    prev_dac <= dac_out;
    if (rb_valid_out === 1'b1 && rb_ready_in === 1'b1) begin
      if (exq.size() == 0) chk("rbextra", 0, 1);
      else chk("rb", exq.pop_front(), {rb_end_out, rb_byte_out});
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1;
    cyc;
    chk("rdyrst", 1, hs_ready_n_out);
    for (k = 0; k < 64; k = k + 1) begin
      @(posedge clk_in);
      tr[k] = seed[27:16];
      wr_en_in <= 1;
      wr_chan_in <= k[5:3];
      wr_index_in <= {7'h00, k[2:0]};
      wr_data_in <= tr[k];
    end
    @(posedge clk_in) wr_en_in <= 0;
    // Repeat period kept above the waveform period
    for (k = 0; k < 2; k = k + 1) begin
      setup(`WPS_KIND_CONT, `WPS_SRC_IMM, 2, k * 20);
      // First start pulse leads its first sample by a clock; skip it
      repeat (2) begin
        cyc;
        while (trig_out !== 1'b1) cyc;
      end
      n = 0;
      do begin
        cyc;
        n = n + 1;
      end while (trig_out !== 1'b1);
      chk("period", k ? 20 : 8, n);
    end
    setup(`WPS_KIND_CONT, `WPS_SRC_IMM, 3, 0);
    repeat (10) cyc;
    @(posedge clk_in) free_run_control_in <= 0;
    repeat (5) cyc;
    // Abort ends play; the last emitted index stays put
    n = point_index_out;
    chk("abort", 0, busy_out);
    repeat (5) cyc;
    chk("abhold", n, point_index_out);
    @(posedge clk_in) burst_count_in <= 3;
    setup(`WPS_KIND_BURST, `WPS_SRC_EXT, 1, 0);
    repeat (4) cyc;
    pull;
    while (busy_out !== 1'b1) cyc;
    n = cyc_n;
    pull;
    while (busy_out === 1'b1) cyc;
    // Three segments of four points at one clock per sample
    chk("burstlen", 3 * 4, cyc_n - n);
    repeat (8) cyc;
    chk("burstend", 3, point_index_out);
    chk("retrig", 0, busy_out);
    setup(`WPS_KIND_SAMPLE, `WPS_SRC_EXT, 1, 0);
    for (k = 0; k < 3; k = k + 1) begin
      repeat (8) cyc;
      pull;
    end
    repeat (8) cyc;
    chk("sample", 2, point_index_out);
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk_in) free_run_control_in <= 0;
      hs_trig_invert_in <= k[0];
      hs_ready_invert_in <= k[0];
      setup(`WPS_KIND_SEGMENT, `WPS_SRC_HAND, 1, 0);
      repeat (4) cyc;
      pull;
      n = 0;
      while (busy_out !== 1'b1 && n < 40) begin
        cyc;
        n = n + 1;
      end
      chk("hshake", 1, busy_out);
    end
    @(posedge clk_in) free_run_control_in <= 0;
    rb(2, `WPS_RB_ALL, 0, 3, 0);
    rb(7, `WPS_RB_ONE, 3, 3, 1);
    rb(3, `WPS_RB_RANGE, 1, 3, 1);
    rb(5, `WPS_RB_RANGE, 2, 1, 0);
    final_report;
  end
endmodule // tb_top

bind waveform_playback_sequencer wps_monitor wps_monitor_inst (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .free_run_control_in(free_run_control_in),
  .points_per_waveform_setting_in(points_per_waveform_setting_in),
  .hs_ready_invert_in(hs_ready_invert_in), .rb_req_in(rb_req_in), .rb_ready_in(rb_ready_in),
  .dac_out(dac_out), .point_index_out(point_index_out), .busy_out(busy_out),
  .trig_out(trig_out), .hs_ready_n_out(hs_ready_n_out), .rb_busy_out(rb_busy_out),
  .rb_valid_out(rb_valid_out), .rb_byte_out(rb_byte_out), .rb_end_out(rb_end_out));
